// ===== inc/hpct_pkg.sv
// Constants, carriers and state types of the host/PCI command translator.
package hpct_pkg;
	localparam int HADDR_W = 36;
	localparam int HDATA_W = 64;
	localparam int HBE_W = HDATA_W / 8;
	localparam int PADDR_W = 32;
	localparam int BYTE_W = 8;
	localparam int CTRL_W = 16;
	localparam logic [7:0] CTRL_OFS = 8'h54;
	localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
	localparam int CTRL_WPOST = 0;
	localparam int CTRL_LINE_MRL = 3;
	localparam int CTRL_LINE_MRM = 5;
	localparam int CTRL_LINE_MR = 8;
	localparam logic [7:0] HSC_SHUTDOWN = 8'h01;
	localparam logic [7:0] HSC_STOP_ACK = 8'h02;
	// Message code value is arbitrary.
	localparam logic [15:0] PSC_STOP_GRANT = 16'h0001;
	localparam logic [3:0] PC_INTACK = 4'h0;
	localparam logic [3:0] PC_SPECIAL = 4'h1;
	localparam logic [3:0] PC_IO_RD = 4'h2;
	localparam logic [3:0] PC_IO_WR = 4'h3;
	localparam logic [3:0] PC_MR = 4'h6;
	localparam logic [3:0] PC_MW = 4'h7;
	localparam logic [3:0] PC_MRM = 4'hC;
	localparam logic [3:0] PC_MRL = 4'hE;
	localparam logic [3:0] PC_MWI = 4'hF;
	localparam logic [3:0] DW_1 = 4'h1;
	localparam logic [3:0] DW_2 = 4'h2;
	localparam logic [3:0] DW_4 = 4'h4;
	localparam logic [3:0] DW_8 = 4'h8;
	localparam logic [3:0] BE_LANE0 = 4'h1;
	localparam logic [3:0] BE_ALL = 4'hF;
	localparam logic [3:0] BE_MAX_IO = 4'h4;
	localparam logic [PADDR_W-1:0] DW_STEP = 32'h0000_0004;
	localparam int OFS_QW = 3;
	localparam int OFS_HALF = 4;
	localparam int OFS_LINE = 5;

	typedef enum logic [3:0] {HC_DEFER_REPLY, HC_INTACK, HC_SPECIAL, HC_IO_RD,
		HC_BTM, HC_IO_WR, HC_READ_INV, HC_CODE_RD, HC_DATA_RD, HC_CENTRAL,
		HC_RSVD, HC_MEM_WR, HC_LINE_WR} hpct_hcmd_t;
	typedef enum logic [1:0] {SZ_LE8, SZ_16, SZ_32} hpct_hsize_t;
	typedef enum logic [1:0] {HS_IDLE, HS_COMMIT, HS_XFER} hpct_hst_t;
	typedef enum logic [1:0] {BS_IDLE, BS_ARB, BS_BUS, BS_WAIT} hpct_bst_t;
	typedef enum logic [1:0] {PS_IDLE, PS_REQ, PS_WAIT} hpct_pst_t;
	typedef enum logic [1:0] {TS_IDLE, TS_LINE, TS_PEND} hpct_tst_t;

	typedef struct packed {
		hpct_hcmd_t cmd;
		hpct_hsize_t length;
		logic [HADDR_W-1:0] addr;
		logic [HBE_W-1:0] be;
	} hpct_hreq_t;

	typedef struct packed {
		logic none;
		logic two;
		logic [3:0] cmd;
		logic [PADDR_W-1:0] addr;
		logic [3:0] be_lo;
		logic [3:0] be_hi;
		logic [3:0] dwords;
	} hpct_pjob_t;

	typedef struct packed {
		logic [3:0] cmd;
		logic [PADDR_W-1:0] addr;
		logic [3:0] be;
		logic [3:0] dwords;
		logic [15:0] msg;
	} hpct_pcmd_t;

	typedef struct packed {
		logic [3:0] cmd;
		logic dac;
		logic [63:0] addr;
		logic cfg_port;
	} hpct_tgt_t;

	typedef struct packed {
		hpct_hcmd_t cmd;
		hpct_hsize_t length;
		logic [HADDR_W-1:0] addr;
	} hpct_hout_t;
endpackage

// ===== logic/hpct_sync.sv
// Three-stage level synchroniser with agreement of the last two stages.
module hpct_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} hpct_sync_st_t;

	hpct_sync_st_t s_r;
	hpct_sync_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.q = s_r.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule

// ===== logic/hpct_translator.sv
// Host/PCI command translator with host and PCI clock domains.
module hpct_translator (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pci_clk,
	input wire logic host_req_valid,
	input wire hpct_pkg::hpct_hreq_t host_req,
	input wire logic host_commit,
	input wire logic mwi_en,
	output logic host_claim,
	output logic host_done,
	output logic pci_req,
	input wire logic pci_gnt,
	output logic pci_cmd_valid,
	output hpct_pkg::hpct_pcmd_t pci_cmd,
	input wire logic pci_cmd_done,
	input wire logic tgt_valid,
	input wire hpct_pkg::hpct_tgt_t tgt,
	input wire logic tgt_line_full,
	input wire logic post_buf_avail,
	input wire logic cfg_claim_en,
	output logic tgt_accept,
	output logic tgt_retry,
	input wire logic dual_bridge,
	output logic peer_req,
	input wire logic peer_grant,
	output logic priority_agent_bus_request,
	input wire logic hbus_ready,
	output logic hout_valid,
	output hpct_pkg::hpct_hout_t hout,
	input wire logic hout_done,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata
);
	typedef struct packed {
		hpct_pkg::hpct_hst_t hst;
		hpct_pkg::hpct_bst_t bst;
		hpct_pkg::hpct_pjob_t job;
		logic h2p_tgl;
		logic cmt_tgl;
		logic h2p_ack_seen;
		logic p2h_seen;
		logic p2h_ack_tgl;
		logic claim;
		logic done;
		logic hvalid;
		hpct_pkg::hpct_hout_t hout;
		logic [hpct_pkg::CTRL_W-1:0] ctrl;
		logic [hpct_pkg::CTRL_W-1:0] rdata;
	} hpct_sys_st_t;

	typedef struct packed {
		hpct_pkg::hpct_pst_t pst;
		hpct_pkg::hpct_tst_t tst;
		logic h2p_seen;
		logic cmt_seen;
		logic h2p_ack_tgl;
		logic half;
		logic cvalid;
		hpct_pkg::hpct_pcmd_t cmd;
		hpct_pkg::hpct_tgt_t tl;
		logic p2h_tgl;
		logic p2h_ack_seen;
		logic accept;
		logic retry;
	} hpct_pci_st_t;

	hpct_sys_st_t s_r;
	hpct_sys_st_t s_nxt;
	hpct_pci_st_t p_r;
	hpct_pci_st_t p_nxt;
	hpct_pkg::hpct_pjob_t hj;
	logic h2p_s;
	logic cmt_s;
	logic h2p_ack_s;
	logic p2h_s;
	logic p2h_ack_s;
	logic issue_ok;

	function automatic logic [hpct_pkg::PADDR_W-1:0] align(
		input logic [hpct_pkg::PADDR_W-1:0] a, input int sh);
		align = (a >> sh) << sh;
	endfunction

	function automatic logic [3:0] ones(input logic [hpct_pkg::HBE_W-1:0] b);
		ones = 4'h0;
		for (int i = 0; i < hpct_pkg::HBE_W; i++) begin
			ones = ones + {3'h0, b[i]};
		end
	endfunction

	// Host request to PCI job; none marks commands that make no PCI cycle.
	function automatic hpct_pkg::hpct_pjob_t xlate_h2p(
		input hpct_pkg::hpct_hreq_t r, input logic mwi);
		hpct_pkg::hpct_pjob_t j;
		logic lo_on;
		logic hi_on;
		logic rd;
		j = '0;
		j.none = 1'b1;
		lo_on = |r.be[3:0];
		hi_on = |r.be[hpct_pkg::HBE_W-1:4];
		rd = (r.cmd != hpct_pkg::HC_MEM_WR);
		j.addr = align(r.addr[hpct_pkg::PADDR_W-1:0], hpct_pkg::OFS_QW);
		j.be_lo = r.be[3:0];
		j.be_hi = r.be[hpct_pkg::HBE_W-1:4];
		j.two = lo_on & hi_on;
		j.dwords = hpct_pkg::DW_1;
		if (!lo_on) begin
			j.addr = j.addr + hpct_pkg::DW_STEP;
			j.be_lo = r.be[hpct_pkg::HBE_W-1:4];
		end
		case (r.cmd)
		hpct_pkg::HC_INTACK: begin
			j.none = (r.length != hpct_pkg::SZ_LE8);
			j.cmd = hpct_pkg::PC_INTACK;
			j.be_lo = hpct_pkg::BE_LANE0;
			j.two = 1'b0;
		end
		hpct_pkg::HC_SPECIAL: begin
			j.none = (r.be != hpct_pkg::HSC_STOP_ACK);
			j.cmd = hpct_pkg::PC_SPECIAL;
			j.two = 1'b0;
		end
		hpct_pkg::HC_IO_RD, hpct_pkg::HC_IO_WR: begin
			j.none = (r.length != hpct_pkg::SZ_LE8) ||
				(ones(r.be) > hpct_pkg::BE_MAX_IO);
			j.cmd = (r.cmd == hpct_pkg::HC_IO_RD) ? hpct_pkg::PC_IO_RD :
				hpct_pkg::PC_IO_WR;
		end
		hpct_pkg::HC_READ_INV: begin
			j.none = 1'b0;
			j.cmd = hpct_pkg::PC_MRL;
			j.two = 1'b0;
			j.dwords = hpct_pkg::DW_8;
			j.be_lo = hpct_pkg::BE_ALL;
			j.addr = align(r.addr[hpct_pkg::PADDR_W-1:0], hpct_pkg::OFS_LINE);
		end
		hpct_pkg::HC_CODE_RD, hpct_pkg::HC_DATA_RD, hpct_pkg::HC_MEM_WR: begin
			j.none = 1'b0;
			j.cmd = rd ? hpct_pkg::PC_MR : hpct_pkg::PC_MW;
			if (r.length == hpct_pkg::SZ_LE8 && (&r.be)) begin
				j.two = 1'b0;
				j.dwords = hpct_pkg::DW_2;
				j.be_lo = hpct_pkg::BE_ALL;
			end else if (r.length == hpct_pkg::SZ_16) begin
				j.two = 1'b0;
				j.dwords = hpct_pkg::DW_4;
				j.be_lo = hpct_pkg::BE_ALL;
				j.addr = align(r.addr[hpct_pkg::PADDR_W-1:0], hpct_pkg::OFS_HALF);
			end else if (r.length == hpct_pkg::SZ_32) begin
				j.two = 1'b0;
				j.dwords = hpct_pkg::DW_8;
				j.be_lo = hpct_pkg::BE_ALL;
				j.addr = align(r.addr[hpct_pkg::PADDR_W-1:0], hpct_pkg::OFS_LINE);
				j.cmd = rd ? hpct_pkg::PC_MRL :
					(mwi ? hpct_pkg::PC_MWI : hpct_pkg::PC_MW);
			end
		end
		default: j.none = 1'b1;
		endcase
		return j;
	endfunction

	// PCI target command to host command, steered by the control register.
	function automatic hpct_pkg::hpct_hout_t xlate_p2h(
		input hpct_pkg::hpct_tgt_t t, input logic [hpct_pkg::CTRL_W-1:0] c);
		hpct_pkg::hpct_hout_t o;
		logic line;
		o.cmd = hpct_pkg::HC_DATA_RD;
		o.length = hpct_pkg::SZ_LE8;
		o.addr = t.dac ? t.addr[hpct_pkg::HADDR_W-1:0] :
			{{(hpct_pkg::HADDR_W-hpct_pkg::PADDR_W){1'b0}},
			t.addr[hpct_pkg::PADDR_W-1:0]};
		line = 1'b0;
		case (t.cmd)
		hpct_pkg::PC_MR: line = c[hpct_pkg::CTRL_LINE_MR];
		hpct_pkg::PC_MRL: line = c[hpct_pkg::CTRL_LINE_MRL];
		hpct_pkg::PC_MRM: line = c[hpct_pkg::CTRL_LINE_MRM];
		hpct_pkg::PC_MW: o.cmd = hpct_pkg::HC_MEM_WR;
		hpct_pkg::PC_MWI: begin
			line = c[hpct_pkg::CTRL_WPOST];
			o.cmd = line ? hpct_pkg::HC_LINE_WR : hpct_pkg::HC_MEM_WR;
		end
		hpct_pkg::PC_IO_RD: o.cmd = hpct_pkg::HC_IO_RD;
		hpct_pkg::PC_IO_WR: o.cmd = hpct_pkg::HC_IO_WR;
		default: o.cmd = hpct_pkg::HC_DATA_RD;
		endcase
		if (line) begin
			o.length = hpct_pkg::SZ_32;
			o.addr[hpct_pkg::OFS_LINE-1:0] = '0;
		end
		return o;
	endfunction

	function automatic logic is_rd(input logic [3:0] c);
		is_rd = (c == hpct_pkg::PC_MR) || (c == hpct_pkg::PC_MRL) ||
			(c == hpct_pkg::PC_MRM) || (c == hpct_pkg::PC_IO_RD);
	endfunction

	// Only the forwardable commands, for this bridge, and not claimed ports.
	function automatic logic fwd(input hpct_pkg::hpct_tgt_t t, input logic ce);
		fwd = (is_rd(t.cmd) || (t.cmd == hpct_pkg::PC_MW) ||
			(t.cmd == hpct_pkg::PC_MWI) || (t.cmd == hpct_pkg::PC_IO_WR)) &&
			!(t.cfg_port && ce) &&
			(!t.dac || (t.addr[63:hpct_pkg::HADDR_W] == '0));
	endfunction

	hpct_sync u_h2p (.clk(pci_clk), .rst_n(rst_n), .d(s_r.h2p_tgl), .q(h2p_s));
	hpct_sync u_cmt (.clk(pci_clk), .rst_n(rst_n), .d(s_r.cmt_tgl), .q(cmt_s));
	hpct_sync u_p2h (.clk(clk_sys), .rst_n(rst_n), .d(p_r.p2h_tgl), .q(p2h_s));
	hpct_sync u_ha (.clk(clk_sys), .rst_n(rst_n), .d(p_r.h2p_ack_tgl),
		.q(h2p_ack_s));
	hpct_sync u_pa (.clk(pci_clk), .rst_n(rst_n), .d(s_r.p2h_ack_tgl),
		.q(p2h_ack_s));

	assign hj = xlate_h2p(host_req, mwi_en);

	always_comb begin
		s_nxt = s_r;
		s_nxt.claim = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.hvalid = 1'b0;
		case (s_r.hst)
		hpct_pkg::HS_IDLE: begin
			if (host_req_valid && host_req.cmd != hpct_pkg::HC_RSVD) begin
				s_nxt.claim = 1'b1;
				if (!hj.none) begin
					s_nxt.job = hj;
					s_nxt.h2p_tgl = ~s_r.h2p_tgl;
					s_nxt.hst = hpct_pkg::HS_COMMIT;
				end else begin
					s_nxt.done = 1'b1;
				end
			end
		end
		hpct_pkg::HS_COMMIT: begin
			if (host_commit) begin
				s_nxt.cmt_tgl = ~s_r.cmt_tgl;
				s_nxt.hst = hpct_pkg::HS_XFER;
			end
		end
		hpct_pkg::HS_XFER: begin
			if (h2p_ack_s != s_r.h2p_ack_seen) begin
				s_nxt.h2p_ack_seen = h2p_ack_s;
				s_nxt.done = 1'b1;
				s_nxt.hst = hpct_pkg::HS_IDLE;
			end
		end
		default: s_nxt.hst = hpct_pkg::HS_IDLE;
		endcase
		case (s_r.bst)
		hpct_pkg::BS_IDLE: begin
			if (p2h_s != s_r.p2h_seen) begin
				s_nxt.p2h_seen = p2h_s;
				s_nxt.bst = dual_bridge ? hpct_pkg::BS_ARB : hpct_pkg::BS_BUS;
			end
		end
		hpct_pkg::BS_ARB: begin
			if (peer_grant) begin
				s_nxt.bst = hpct_pkg::BS_BUS;
			end
		end
		hpct_pkg::BS_BUS: begin
			if (hbus_ready) begin
				s_nxt.hvalid = 1'b1;
				s_nxt.hout = xlate_p2h(p_r.tl, s_r.ctrl);
				s_nxt.bst = hpct_pkg::BS_WAIT;
			end
		end
		hpct_pkg::BS_WAIT: begin
			if (hout_done) begin
				s_nxt.p2h_ack_tgl = ~s_r.p2h_ack_tgl;
				s_nxt.bst = hpct_pkg::BS_IDLE;
			end
		end
		default: s_nxt.bst = hpct_pkg::BS_IDLE;
		endcase
		if (cfg_we && cfg_addr == hpct_pkg::CTRL_OFS) begin
			for (int i = 0; i < 2; i++) begin
				if (cfg_be[i]) begin
					s_nxt.ctrl[i*hpct_pkg::BYTE_W +: hpct_pkg::BYTE_W] =
						cfg_wdata[i*hpct_pkg::BYTE_W +: hpct_pkg::BYTE_W];
				end
			end
		end
		s_nxt.rdata = (cfg_addr == hpct_pkg::CTRL_OFS) ? s_r.ctrl : '0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.ctrl <= hpct_pkg::CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// The second half needs no fresh commit; the first waits for one.
	assign issue_ok = pci_gnt && (p_r.half || cmt_s != p_r.cmt_seen);

	always_comb begin
		p_nxt = p_r;
		p_nxt.cvalid = 1'b0;
		p_nxt.accept = 1'b0;
		p_nxt.retry = 1'b0;
		case (p_r.pst)
		hpct_pkg::PS_IDLE: begin
			if (h2p_s != p_r.h2p_seen) begin
				p_nxt.h2p_seen = h2p_s;
				p_nxt.half = 1'b0;
				p_nxt.pst = hpct_pkg::PS_REQ;
			end
		end
		hpct_pkg::PS_REQ: begin
			if (issue_ok) begin
				p_nxt.cmt_seen = cmt_s;
				p_nxt.cvalid = 1'b1;
				p_nxt.cmd.cmd = s_r.job.cmd;
				p_nxt.cmd.addr = p_r.half ? s_r.job.addr + hpct_pkg::DW_STEP :
					s_r.job.addr;
				p_nxt.cmd.be = p_r.half ? s_r.job.be_hi : s_r.job.be_lo;
				p_nxt.cmd.dwords = p_r.half ? hpct_pkg::DW_1 : s_r.job.dwords;
				p_nxt.cmd.msg = hpct_pkg::PSC_STOP_GRANT;
				p_nxt.pst = hpct_pkg::PS_WAIT;
			end
		end
		hpct_pkg::PS_WAIT: begin
			if (pci_cmd_done) begin
				if (s_r.job.two && !p_r.half) begin
					p_nxt.half = 1'b1;
					p_nxt.pst = hpct_pkg::PS_REQ;
				end else begin
					p_nxt.h2p_ack_tgl = ~p_r.h2p_ack_tgl;
					p_nxt.pst = hpct_pkg::PS_IDLE;
				end
			end
		end
		default: p_nxt.pst = hpct_pkg::PS_IDLE;
		endcase
		case (p_r.tst)
		hpct_pkg::TS_IDLE: begin
			if (tgt_valid && fwd(tgt, cfg_claim_en)) begin
				p_nxt.tl = tgt;
				if (!post_buf_avail) begin
					p_nxt.retry = 1'b1;
					if (is_rd(tgt.cmd)) begin
						p_nxt.p2h_tgl = ~p_r.p2h_tgl;
						p_nxt.tst = hpct_pkg::TS_PEND;
					end
				end else begin
					p_nxt.accept = 1'b1;
					if (tgt.cmd == hpct_pkg::PC_MWI) begin
						p_nxt.tst = hpct_pkg::TS_LINE;
					end else begin
						p_nxt.p2h_tgl = ~p_r.p2h_tgl;
						p_nxt.tst = hpct_pkg::TS_PEND;
					end
				end
			end
		end
		hpct_pkg::TS_LINE: begin
			p_nxt.retry = tgt_valid;
			if (tgt_line_full) begin
				p_nxt.p2h_tgl = ~p_r.p2h_tgl;
				p_nxt.tst = hpct_pkg::TS_PEND;
			end
		end
		hpct_pkg::TS_PEND: begin
			p_nxt.retry = tgt_valid;
			if (p2h_ack_s != p_r.p2h_ack_seen) begin
				p_nxt.p2h_ack_seen = p2h_ack_s;
				p_nxt.tst = hpct_pkg::TS_IDLE;
			end
		end
		default: p_nxt.tst = hpct_pkg::TS_IDLE;
		endcase
	end

	always_ff @(posedge pci_clk or negedge rst_n) begin
		if (!rst_n) begin
			p_r <= '0;
		end else begin
			p_r <= p_nxt;
		end
	end

	assign host_claim = s_r.claim;
	assign host_done = s_r.done;
	assign hout_valid = s_r.hvalid;
	assign hout = s_r.hout;
	assign cfg_rdata = s_r.rdata;
	assign priority_agent_bus_request = (s_r.bst == hpct_pkg::BS_BUS) ||
		(s_r.bst == hpct_pkg::BS_WAIT);
	assign peer_req = dual_bridge && (s_r.bst != hpct_pkg::BS_IDLE);
	assign pci_req = (p_r.pst != hpct_pkg::PS_IDLE);
	assign pci_cmd_valid = p_r.cvalid;
	assign pci_cmd = p_r.cmd;
	assign tgt_accept = p_r.accept;
	assign tgt_retry = p_r.retry;

	commit_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$changed(s_r.cmt_tgl) |-> $past(host_commit) &&
		$past(s_r.hst) == hpct_pkg::HS_COMMIT)
		else $error("Commit crossing moved without a host commit.");
	reserved_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		host_req_valid && s_r.hst == hpct_pkg::HS_IDLE &&
		host_req.cmd == hpct_pkg::HC_RSVD |=> !host_claim &&
		s_r.hst == hpct_pkg::HS_IDLE)
		else $error("Reserved host command was claimed.");
	special_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		host_req_valid && s_r.hst == hpct_pkg::HS_IDLE &&
		host_req.cmd == hpct_pkg::HC_SPECIAL &&
		host_req.be != hpct_pkg::HSC_STOP_ACK |=> host_done &&
		s_r.hst == hpct_pkg::HS_IDLE)
		else $error("Non stop-clock special cycle started a PCI cycle.");
	read_inv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		host_req_valid && s_r.hst == hpct_pkg::HS_IDLE &&
		host_req.cmd == hpct_pkg::HC_READ_INV |=>
		s_r.job.cmd == hpct_pkg::PC_MRL && s_r.job.dwords == hpct_pkg::DW_8)
		else $error("Read invalidate not mapped to an 8-dword read line.");
	burst_four_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		host_req_valid && s_r.hst == hpct_pkg::HS_IDLE &&
		host_req.cmd == hpct_pkg::HC_DATA_RD &&
		host_req.length == hpct_pkg::SZ_16 |=> s_r.job.dwords == hpct_pkg::DW_4)
		else $error("16-byte read not mapped to a 4-dword burst.");
	peer_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_r.bst == hpct_pkg::BS_ARB |-> peer_req && !priority_agent_bus_request)
		else $error("Priority request raised before peer arbitration.");
	line_ctrl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_r.hvalid && is_rd(p_r.tl.cmd) && p_r.tl.cmd != hpct_pkg::PC_IO_RD |->
		(s_r.hout.length == hpct_pkg::SZ_32) ==
		$past((p_r.tl.cmd == hpct_pkg::PC_MR && s_r.ctrl[hpct_pkg::CTRL_LINE_MR])
		|| (p_r.tl.cmd == hpct_pkg::PC_MRL && s_r.ctrl[hpct_pkg::CTRL_LINE_MRL])
		|| (p_r.tl.cmd == hpct_pkg::PC_MRM && s_r.ctrl[hpct_pkg::CTRL_LINE_MRM])))
		else $error("Host read length disagrees with the control bits.");
	no_special_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_r.hvalid |-> p_r.tl.cmd != hpct_pkg::PC_SPECIAL)
		else $error("PCI special cycle was forwarded to the host.");
	intack_lane_a: assert property (@(posedge pci_clk) disable iff (!rst_n)
		p_r.cvalid && p_r.cmd.cmd == hpct_pkg::PC_INTACK |->
		p_r.cmd.be == hpct_pkg::BE_LANE0 && p_r.cmd.dwords == hpct_pkg::DW_1)
		else $error("Interrupt acknowledge without lane 0 only.");
	busy_retry_a: assert property (@(posedge pci_clk) disable iff (!rst_n)
		tgt_valid && p_r.tst != hpct_pkg::TS_IDLE |=> tgt_retry)
		else $error("Master not retried while buffers were busy.");
	line_wait_a: assert property (@(posedge pci_clk) disable iff (!rst_n)
		p_r.tst == hpct_pkg::TS_LINE && !tgt_line_full |=>
		p_r.tst == hpct_pkg::TS_LINE && $stable(p_r.p2h_tgl))
		else $error("Line write forwarded before the line was full.");
	split_lanes_a: assert property (@(posedge pci_clk) disable iff (!rst_n)
		p_r.cvalid && p_r.half |-> p_r.cmd.be == s_r.job.be_hi &&
		p_r.cmd.addr == s_r.job.addr + hpct_pkg::DW_STEP)
		else $error("Second split cycle carries wrong lanes or address.");
endmodule

// ===== verification/hpct_pci_model.sv
// PCI side arbiter and target model that faces the translator.
module hpct_pci_model (
	input wire logic pci_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic pci_req,
	input wire logic pci_cmd_valid,
	output logic pci_gnt,
	output logic pci_cmd_done
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt;
	// Grant follows the request a cycle late and falls a cycle after it.
	always @(posedge pci_clk or negedge rst_n) begin
		if (!rst_n) begin
			pci_gnt <= 1'h0;
			pci_cmd_done <= 1'h0;
			cnt <= 0;
		end else begin
			pci_gnt <= pci_req;
			pci_cmd_done <= (cnt == 1);
			if (pci_cmd_valid)
				cnt <= slow ? 6 : 2;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// ===== verification/tb_hpct_translator.sv
// Self-checking bench for the host/PCI command translator.
module tb_hpct_translator;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'h0;
	logic pci_clk = 1'h0;
	logic rst_n = 1'h0;
	logic host_req_valid = 1'h0;
	logic host_commit = 1'h0;
	logic mwi_en = 1'h0;
	logic tgt_valid = 1'h0;
	logic post_buf_avail = 1'h1;
	logic cfg_claim_en = 1'h0;
	logic hout_done = 1'h0;
	logic cfg_we = 1'h0;
	logic slow = 1'h0;
	logic dual_bridge = 1'h1;
	logic [2:0] gather = 3'h0;
	logic [1:0] cfg_be = 2'h3;
	logic [7:0] cfg_addr = 8'h54;
	logic [15:0] cfg_wdata = 16'h0000;
	hpct_pkg::hpct_hreq_t host_req = '0;
	hpct_pkg::hpct_tgt_t tgt = '0;
	logic host_claim, host_done, pci_req, pci_gnt, pci_cmd_valid;
	logic pci_cmd_done, tgt_accept, tgt_retry, peer_req, prio, hout_valid;
	logic [15:0] cfg_rdata;
	hpct_pkg::hpct_pcmd_t pci_cmd;
	hpct_pkg::hpct_hout_t hout;
	hpct_pkg::hpct_pcmd_t pq[$];
	hpct_pkg::hpct_hout_t hq[$];
	int n_done = 0;
	int n_fail = 0;
	int total_checks = 0;

	initial forever #5 clk_sys = ~clk_sys;
	initial begin
		#12.5;
		forever #32 pci_clk = ~pci_clk;
	end

	// The second bridge of the pair grants at once.
	hpct_translator dut (.clk_sys(clk_sys), .rst_n(rst_n), .pci_clk(pci_clk),
		.host_req_valid(host_req_valid), .host_req(host_req),
		.host_commit(host_commit), .mwi_en(mwi_en), .host_claim(host_claim),
		.host_done(host_done), .pci_req(pci_req), .pci_gnt(pci_gnt),
		.pci_cmd_valid(pci_cmd_valid), .pci_cmd(pci_cmd),
		.pci_cmd_done(pci_cmd_done), .tgt_valid(tgt_valid), .tgt(tgt),
		.tgt_line_full(gather[2]), .post_buf_avail(post_buf_avail),
		.cfg_claim_en(cfg_claim_en), .tgt_accept(tgt_accept),
		.tgt_retry(tgt_retry), .dual_bridge(dual_bridge), .peer_req(peer_req),
		.peer_grant(peer_req), .priority_agent_bus_request(prio),
		.hbus_ready(1'h1), .hout_valid(hout_valid), .hout(hout),
		.hout_done(hout_done), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

	hpct_pci_model pci (.pci_clk(pci_clk), .rst_n(rst_n), .slow(slow),
		.pci_req(pci_req), .pci_cmd_valid(pci_cmd_valid), .pci_gnt(pci_gnt),
		.pci_cmd_done(pci_cmd_done));

	always @(posedge pci_clk) if (pci_cmd_valid === 1'h1) pq.push_back(pci_cmd);
	always @(posedge clk_sys) if (hout_valid === 1'h1) hq.push_back(hout);
	always @(posedge clk_sys) if (host_done === 1'h1) n_done++;
	// The master's line is complete three PCI cycles after an accept.
	always @(posedge pci_clk) gather <= {gather[1:0], tgt_accept};

	task automatic chk(input string nm, input logic [63:0] s,
		input logic [63:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cwr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys) #1;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_we = 1'h1;
		@(posedge clk_sys) #1;
		cfg_we = 1'h0;
	endtask

	task automatic crd(input logic [7:0] a, input logic [15:0] e);
		cfg_addr = a;
		@(posedge clk_sys) #1;
		chk("ctrl", cfg_rdata, e);
	endtask

	// Expected word e packs command, burst length and lane enables.
	task automatic hop(input hpct_pkg::hpct_hcmd_t c, input logic [1:0] l,
		input logic [7:0] be, input int n, input logic [11:0] e);
		int d0;
		int i;
		logic cl;
		d0 = n_done;
		pq.delete();
		host_req = '{c, hpct_pkg::hpct_hsize_t'(l), 36'h8_0000_1000, be};
		host_req_valid = 1'h1;
		for (i = 0; i < 20 && host_claim !== 1'h1; i++)
			@(posedge clk_sys) #1;
		cl = host_claim;
		host_req_valid = 1'h0;
		chk("claim", cl, c != hpct_pkg::HC_RSVD);
		if (n > 0) begin
			repeat (40) @(posedge clk_sys);
			#1;
			chk("early cmd", pq.size(), 0);
			chk("pci req", pci_req, 1);
			host_commit = 1'h1;
			@(posedge clk_sys) #1;
			host_commit = 1'h0;
		end
		for (i = 0; i < 900 && n_done == d0 && cl; i++)
			@(posedge clk_sys) #1;
		chk("done", n_done - d0, cl);
		chk("count", pq.size(), n);
		if (n_done == d0 && cl)
			end_sim();
		if (n > 0) begin
			chk("cmd", {pq[0].cmd, pq[0].dwords}, e[11:4]);
			if (e[3:0] != 4'h0)
				chk("be", pq[0].be, e[3:0]);
			if (e[7:4] > 4'h1)
				chk("addr", pq[0].addr, 32'h1000);
			if (c == hpct_pkg::HC_SPECIAL)
				chk("msg", pq[0].msg, hpct_pkg::PSC_STOP_GRANT);
		end
	endtask

	// Expected e packs host command and length; zero means dropped.
	task automatic top(input logic [3:0] c, input logic [63:0] a,
		input logic cp, input logic [1:0] ar, input logic [5:0] e);
		int i;
		logic [1:0] ok;
		hq.delete();
		@(posedge pci_clk) #1;
		tgt = '{c, a[63:32] != 32'h0, a, cp};
		tgt_valid = 1'h1;
		@(posedge pci_clk) #1;
		tgt_valid = 1'h0;
		ok = {tgt_accept, tgt_retry};
		chk("accept", ok, ar);
		for (i = 0; i < 300 && hq.size() == 0; i++)
			@(posedge clk_sys) #1;
		chk("fwd", hq.size(), e != 6'h0);
		if (hq.size() > 0) begin
			chk("prio", prio, 1);
			chk("peer", peer_req, dual_bridge);
			chk("hout", {hq[0].cmd, hq[0].length}, e);
			hout_done = 1'h1;
			@(posedge clk_sys) #1;
			hout_done = 1'h0;
		end
		repeat (12) @(posedge pci_clk);
		#1;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1'h1;
		crd(8'h54, 16'h0000);
		hop(hpct_pkg::HC_MEM_WR, 2'h0, 8'hFF, 1, 12'h72F);
		hop(hpct_pkg::HC_DATA_RD, 2'h1, 8'hFF, 1, 12'h64F);
		hop(hpct_pkg::HC_CODE_RD, 2'h2, 8'hFF, 1, 12'hE8F);
		hop(hpct_pkg::HC_READ_INV, 2'h0, 8'h01, 1, 12'hE8F);
		hop(hpct_pkg::HC_INTACK, 2'h0, 8'hFF, 1, 12'h011);
		hop(hpct_pkg::HC_SPECIAL, 2'h0, 8'h02, 1, 12'h110);
		hop(hpct_pkg::HC_SPECIAL, 2'h0, 8'h01, 0, 12'h000);
		hop(hpct_pkg::HC_IO_WR, 2'h0, 8'h0F, 1, 12'h31F);
		hop(hpct_pkg::HC_IO_RD, 2'h0, 8'hF0, 1, 12'h21F);
		hop(hpct_pkg::HC_MEM_WR, 2'h0, 8'h3C, 2, 12'h71C);
		chk("be hi", pq[1].be, 4'h3);
		chk("addr hi", pq[1].addr, 32'h1004);
		hop(hpct_pkg::HC_RSVD, 2'h0, 8'hFF, 0, 12'h000);
		hop(hpct_pkg::HC_DEFER_REPLY, 2'h0, 8'hFF, 0, 12'h000);
		mwi_en = 1'h1;
		slow = 1'h1;
		hop(hpct_pkg::HC_MEM_WR, 2'h2, 8'hFF, 1, 12'hF8F);
		mwi_en = 1'h0;
		hop(hpct_pkg::HC_MEM_WR, 2'h2, 8'hFF, 1, 12'h78F);
		top(hpct_pkg::PC_MR, 64'h1000, 1'h0, 2'h2, 6'h20);
		cwr(8'h54, 16'h0129);
		cwr(8'h56, 16'hFFFF);
		crd(8'h56, 16'h0000);
		crd(8'h54, 16'h0129);
		top(hpct_pkg::PC_MR, 64'h1000, 1'h0, 2'h2, 6'h22);
		top(hpct_pkg::PC_MRL, 64'h1000, 1'h0, 2'h2, 6'h22);
		top(hpct_pkg::PC_MRM, 64'h1000, 1'h0, 2'h2, 6'h22);
		top(hpct_pkg::PC_MWI, 64'h1000, 1'h0, 2'h2, 6'h32);
		top(hpct_pkg::PC_MW, 64'h1000, 1'h0, 2'h2, 6'h2C);
		top(hpct_pkg::PC_IO_WR, 64'h1000, 1'h0, 2'h2, 6'h14);
		top(hpct_pkg::PC_SPECIAL, 64'h1000, 1'h0, 2'h0, 6'h00);
		top(hpct_pkg::PC_MR, 64'h8_1234_5660, 1'h0, 2'h2, 6'h22);
		chk("dac addr", hq[0].addr, 36'h8_1234_5660);
		top(hpct_pkg::PC_MR, 64'h1_0000_0000_1000, 1'h0, 2'h0, 6'h00);
		dual_bridge = 1'h0;
		top(hpct_pkg::PC_IO_RD, 64'hCF8, 1'h1, 2'h2, 6'h0C);
		cfg_claim_en = 1'h1;
		top(hpct_pkg::PC_IO_RD, 64'hCF8, 1'h1, 2'h0, 6'h00);
		post_buf_avail = 1'h0;
		top(hpct_pkg::PC_MW, 64'h1000, 1'h0, 2'h1, 6'h00);
		end_sim();
	end
endmodule
